// >>> logic/adc_config_irq_registers.sv
// AXI4-Lite register bank: gain, bias, conversion sequencing, result layout and status flags
// Notes on behaviour
// RULE1: Gain code 000..111 means 1/3, 1, 2, 4, 8, 16, 32, 64; reset is 001.
// RULE2: Gains 32 and 64 use analog 16 with digital times two or four.
// RULE3: Bias field 11 double, 10 unity (reset), 01 0.66, 00 half.
// RULE4: Chop set doubles conversion time and turns continuous into repeated single shots.
// RULE5: Sequencing 11 converts or scans continuously.
// RULE6: Sequencing 10 does one conversion then sets mode to standby.
// RULE7: Sequencing 0X, the reset value, does one conversion then sets mode to shutdown.
// RULE8: Mode 11 converting, 10 standby, 01/00 shutdown; 00 after reset.
// RULE9: Layout 11 gives channel id, 12 sign bits, 16-bit sample.
// RULE10: Layout 10 gives 16 sign bits over the 16-bit sample.
// RULE11: Layout 01 gives the sample in the upper half, zeros below.
// RULE12: Layout 00 is bare 16 bits; layouts 00/01 saturate at 0xFFFF or 0x8000.
// RULE13: Checksum width 1 appends CRC plus sixteen zeros, 0 only the CRC.
// RULE14: Read CRC only while enabled; these bits leave configuration checksum untouched.
// RULE15: Offset correction applies only while its enable is set; reset clear.
// RULE16: Gain correction applies only while its enable, bit 0, is set; reset clear.
// RULE17: Ready flag reads 0 on a new result, 1 after reading it or reset.
// RULE18: Integrity flag reads 1 until a configuration checksum error, then 0.
// RULE19: Status bit 7 always reads zero and ignores writes.
// RULE20: Bias, gain and chop reach the front end as registered static outputs.
`timescale 1ns/1ps

module adc_config_irq_registers (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic [2:0]                      awprot,
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [adc_cfg_pkg::DATA_W-1:0]  wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    input  wire logic [adc_cfg_pkg::ADDR_W-1:0]  araddr,
    input  wire logic [2:0]                      arprot,
    input  wire logic                            arvalid,
    output logic                                 arready,
    output logic [adc_cfg_pkg::DATA_W-1:0]       rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    input  wire adc_cfg_pkg::sample_t            sample,
    input  wire adc_cfg_pkg::cal_t               cal,
    input  wire logic                            config_checksum_error,
    output adc_cfg_pkg::afe_ctrl_t               afe,
    output adc_cfg_pkg::link_crc_t               link_crc,
    output logic                                 offset_correction_enable,
    output logic                                 gain_correction_enable,
    output logic [adc_cfg_pkg::DATA_W-1:0]       conversion_result,
    output logic                                 result_ready_flag_n,
    output logic                                 config_integrity_flag_n
);

    typedef struct packed {
        logic [7:0]                 gain_bias;
        logic [7:0]                 conv_fmt;
        logic [3:0]                 irq_low;
        adc_cfg_pkg::op_mode_t      mode;
        logic                       ready_n;
        logic                       integ_n;
        logic [31:0]                result;
        logic                       busy;
        logic                       start;
        logic                       aw_full;
        logic [adc_cfg_pkg::ADDR_W-1:0] aw_addr;
        logic                       w_full;
        logic [7:0]                 w_data;
        logic                       w_lane0;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
        logic                       rd_status;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [2:0]         gain_code;
    logic [2:0]         gain_analog;
    logic [1:0]         gain_shift;
    logic [1:0]         seq;

    logic signed [23:0] v_raw;
    logic signed [23:0] v_off;
    logic signed [40:0] prod;
    logic signed [23:0] v_cal;
    logic [16:0]        v17;
    logic [15:0]        v16;
    logic [31:0]        formatted;
    logic               accept;

    function automatic logic mapped(input logic [adc_cfg_pkg::ADDR_W-1:0] a);
        logic [5:0] idx;
        idx = a[adc_cfg_pkg::ADDR_W-1:2];
        mapped = (a[1:0] == 2'h0)
              && (idx == adc_cfg_pkg::IDX_RESULT || idx == adc_cfg_pkg::IDX_MODE
               || idx == adc_cfg_pkg::IDX_GAIN_BIAS || idx == adc_cfg_pkg::IDX_CONV_FMT
               || idx == adc_cfg_pkg::IDX_IRQ_STATUS);
    endfunction : mapped

    // Gain decode into analog stage and digital shift
    always_comb
    begin
        gain_code = s_q.gain_bias[adc_cfg_pkg::GAIN_LSB +: 3];
        seq       = s_q.conv_fmt[adc_cfg_pkg::SEQ_LSB +: 2];
        case (gain_code)
            adc_cfg_pkg::GAIN_X64:
            begin
                gain_analog = adc_cfg_pkg::GAIN_X16; // RULE2
                gain_shift  = adc_cfg_pkg::SHIFT_X4;
            end
            adc_cfg_pkg::GAIN_X32:
            begin
                gain_analog = adc_cfg_pkg::GAIN_X16; // RULE2
                gain_shift  = adc_cfg_pkg::SHIFT_X2;
            end
            default:
            begin
                gain_analog = gain_code; // RULE1
                gain_shift  = 2'h0;
            end
        endcase
    end

    // Result datapath: digital gain, corrections, layout
    always_comb
    begin
        v_raw = $signed({{7{sample.data[16]}}, sample.data}) <<< gain_shift;
        if (s_q.conv_fmt[adc_cfg_pkg::OFF_EN_BIT])
            v_off = v_raw - $signed({{8{cal.offset[15]}}, cal.offset}); // RULE15
        else
            v_off = v_raw;
        prod = v_off * $signed({1'b0, cal.gain});
        if (s_q.conv_fmt[adc_cfg_pkg::GAIN_EN_BIT])
            v_cal = prod[38:15]; // RULE16
        else
            v_cal = v_off;
        if (v_cal > adc_cfg_pkg::MAX17)
            v17 = 17'h0FFFF;
        else if (v_cal < adc_cfg_pkg::MIN17)
            v17 = 17'h10000;
        else
            v17 = v_cal[16:0];
        if (v_cal > adc_cfg_pkg::MAX16)
            v16 = adc_cfg_pkg::SAT_POS; // RULE12
        else if (v_cal < adc_cfg_pkg::MIN16)
            v16 = adc_cfg_pkg::SAT_NEG; // RULE12
        else
            v16 = v_cal[15:0];
        case (adc_cfg_pkg::layout_t'(s_q.conv_fmt[adc_cfg_pkg::LAYOUT_LSB +: 2]))
            adc_cfg_pkg::LAYOUT_CHAN32: formatted = {sample.channel, {12{v17[16]}}, v17[15:0]}; // RULE9
            adc_cfg_pkg::LAYOUT_SIGN32: formatted = {{16{v17[16]}}, v17[15:0]}; // RULE10
            adc_cfg_pkg::LAYOUT_LEFT32: formatted = {v16, 16'h0000}; // RULE11
            default:                    formatted = {16'h0000, v16}; // RULE12
        endcase
    end

    assign accept = sample.valid && s_q.mode == adc_cfg_pkg::MODE_CONVERT && s_q.busy;

    // Next-state logic
    always_comb
    begin
        s_d       = s_q;
        s_d.start = 1'b0;

        if (awvalid && !s_q.aw_full)
        begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && !s_q.w_full)
        begin
            s_d.w_full  = 1'b1;
            s_d.w_data  = wdata[7:0];
            s_d.w_lane0 = wstrb[0];
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;

        if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
        begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = mapped(s_q.aw_addr) ? adc_cfg_pkg::RESP_OKAY : adc_cfg_pkg::RESP_SLVERR;
            if (s_q.w_lane0 && s_q.aw_addr[1:0] == 2'h0)
            begin
                case (s_q.aw_addr[adc_cfg_pkg::ADDR_W-1:2])
                    adc_cfg_pkg::IDX_MODE:       s_d.mode = adc_cfg_pkg::op_mode_t'(s_q.w_data[1:0]);
                    adc_cfg_pkg::IDX_GAIN_BIAS:  s_d.gain_bias = s_q.w_data;
                    adc_cfg_pkg::IDX_CONV_FMT:   s_d.conv_fmt = s_q.w_data;
                    adc_cfg_pkg::IDX_IRQ_STATUS: s_d.irq_low = s_q.w_data[3:0]; // RULE19
                    default:                     s_d.irq_low = s_q.irq_low;
                endcase
            end
        end

        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && !s_q.rvalid)
        begin
            s_d.rvalid    = 1'b1;
            s_d.rresp     = mapped(araddr) ? adc_cfg_pkg::RESP_OKAY : adc_cfg_pkg::RESP_SLVERR;
            s_d.rd_status = 1'b0;
            s_d.rdata     = 32'h0000_0000;
            if (araddr[1:0] == 2'h0)
            begin
                case (araddr[adc_cfg_pkg::ADDR_W-1:2])
                    adc_cfg_pkg::IDX_RESULT:
                    begin
                        s_d.rdata   = s_q.result;
                        s_d.ready_n = 1'b1; // RULE17
                    end
                    adc_cfg_pkg::IDX_MODE:       s_d.rdata = {30'h0, s_q.mode};
                    adc_cfg_pkg::IDX_GAIN_BIAS:  s_d.rdata = {24'h0, s_q.gain_bias};
                    adc_cfg_pkg::IDX_CONV_FMT:   s_d.rdata = {24'h0, s_q.conv_fmt};
                    adc_cfg_pkg::IDX_IRQ_STATUS:
                    begin
                        s_d.rdata     = {24'h0, 1'b0, s_q.ready_n, s_q.integ_n, 1'b1, s_q.irq_low}; // RULE19
                        s_d.rd_status = 1'b1;
                    end
                    default:                     s_d.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Conversion sequencing
        if (s_q.mode != adc_cfg_pkg::MODE_CONVERT)
            s_d.busy = 1'b0;
        else if (!s_q.busy)
        begin
            s_d.busy  = 1'b1; // RULE4
            s_d.start = 1'b1;
        end
        if (accept)
        begin
            s_d.result  = formatted;
            s_d.ready_n = 1'b0; // RULE17
            s_d.busy    = 1'b0;
            if (seq == adc_cfg_pkg::SEQ_CONT)
                s_d.mode = adc_cfg_pkg::MODE_CONVERT; // RULE5
            else if (seq == adc_cfg_pkg::SEQ_STANDBY)
                s_d.mode = adc_cfg_pkg::MODE_STANDBY; // RULE6
            else
                s_d.mode = adc_cfg_pkg::MODE_SHUT; // RULE7
        end

        if (config_checksum_error)
            s_d.integ_n = 1'b0; // RULE18
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q           <= '0;
            s_q.gain_bias <= adc_cfg_pkg::GAIN_BIAS_RST; // RULE1
            s_q.conv_fmt  <= adc_cfg_pkg::CONV_FMT_RST;
            s_q.irq_low   <= adc_cfg_pkg::IRQ_LOW_RST;
            s_q.mode      <= adc_cfg_pkg::MODE_SHUT; // RULE8
            s_q.ready_n   <= 1'b1;
            s_q.integ_n   <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign awready = !s_q.aw_full;
    assign wready  = !s_q.w_full;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = !s_q.rvalid;
    assign rvalid  = s_q.rvalid;
    assign rdata   = s_q.rdata;
    assign rresp   = s_q.rresp;

    always_comb
    begin
        afe.bias_current_scale = s_q.gain_bias[adc_cfg_pkg::BIAS_LSB +: 2]; // RULE3 RULE20
        afe.gain_analog        = gain_analog; // RULE20
        afe.gain_shift         = gain_shift;
        afe.auto_zero_chop_en  = s_q.gain_bias[adc_cfg_pkg::CHOP_BIT]; // RULE20
        afe.converting         = s_q.mode == adc_cfg_pkg::MODE_CONVERT; // RULE8
        afe.continuous         = seq == adc_cfg_pkg::SEQ_CONT && !s_q.gain_bias[adc_cfg_pkg::CHOP_BIT]; // RULE4
        afe.start              = s_q.start;
    end

    always_comb
    begin
        link_crc.link_checksum_enable = s_q.conv_fmt[adc_cfg_pkg::CRC_EN_BIT]; // RULE14
        link_crc.pad_zeros            = s_q.conv_fmt[adc_cfg_pkg::CRC_W_BIT];
        if (!s_q.conv_fmt[adc_cfg_pkg::CRC_EN_BIT])
            link_crc.trailer_bits = 6'h00; // RULE14
        else if (s_q.conv_fmt[adc_cfg_pkg::CRC_W_BIT])
            link_crc.trailer_bits = adc_cfg_pkg::CRC_BITS + adc_cfg_pkg::CRC_PAD_BITS; // RULE13
        else
            link_crc.trailer_bits = adc_cfg_pkg::CRC_BITS; // RULE13
    end

    assign offset_correction_enable = s_q.conv_fmt[adc_cfg_pkg::OFF_EN_BIT];
    assign gain_correction_enable   = s_q.conv_fmt[adc_cfg_pkg::GAIN_EN_BIT];
    assign conversion_result        = s_q.result;
    assign result_ready_flag_n      = s_q.ready_n;
    assign config_integrity_flag_n  = s_q.integ_n;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_gain_split;
        gain_code == adc_cfg_pkg::GAIN_X64 |-> afe.gain_analog == 3'h5 && afe.gain_shift == 2'h2;
    endproperty
    a_gain_split: assert property (p_gain_split) else $error("gain 64 split wrong"); // RULE2

    property p_gain_low;
        gain_code < adc_cfg_pkg::GAIN_X32 |-> afe.gain_analog == gain_code && afe.gain_shift == 2'h0;
    endproperty
    a_gain_low: assert property (p_gain_low) else $error("low gain decode wrong"); // RULE1

    property p_bias_write;
        s_q.aw_full && s_q.w_full && !s_q.bvalid && s_q.w_lane0
            && s_q.aw_addr == {adc_cfg_pkg::IDX_GAIN_BIAS, 2'h0}
        |=> afe.bias_current_scale == $past(s_q.w_data[7:6]) && afe.auto_zero_chop_en == $past(s_q.w_data[2]);
    endproperty
    a_bias_write: assert property (p_bias_write) else $error("front end not updated"); // RULE20

    property p_chop_single;
        afe.auto_zero_chop_en |-> !afe.continuous;
    endproperty
    a_chop_single: assert property (p_chop_single) else $error("chop with continuous run"); // RULE4

    property p_cont;
        accept && seq == 2'h3 |=> afe.converting ##1 afe.start;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode stopped"); // RULE5

    property p_standby;
        accept && seq == 2'h2 |=> s_q.mode == adc_cfg_pkg::MODE_STANDBY && !afe.converting;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby after one shot"); // RULE6

    property p_shutdown;
        accept && !seq[1] |=> s_q.mode == adc_cfg_pkg::MODE_SHUT;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown after one shot"); // RULE7

    property p_ready_fall;
        accept |=> !result_ready_flag_n && conversion_result == $past(formatted);
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("result or ready flag missing"); // RULE17

    property p_integ_sticky;
        !config_integrity_flag_n |=> !config_integrity_flag_n [*3];
    endproperty
    a_integ_sticky: assert property (p_integ_sticky) else $error("integrity flag recovered"); // RULE18

    property p_bit7;
        rvalid && s_q.rd_status |-> rdata[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7) else $error("status bit 7 not zero"); // RULE19

    property p_crc_len;
        link_crc.link_checksum_enable |-> link_crc.trailer_bits == (link_crc.pad_zeros ? 6'h20 : 6'h10);
    endproperty
    a_crc_len: assert property (p_crc_len) else $error("checksum trailer length wrong"); // RULE13

    property p_write_resp;
        s_q.aw_full && s_q.w_full && !s_q.bvalid |=> bvalid ##0 (awready && wready);
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");

    c_one_shot: cover property (accept && seq == 2'h2);
    c_status_read: cover property (rvalid && s_q.rd_status);
    c_high_gain: cover property (accept && gain_code == adc_cfg_pkg::GAIN_X64);

endmodule : adc_config_irq_registers

// >>> logic/adc_cfg_pkg.sv
// Package: register map, field layout, reset values and carrier types of the ADC configuration block
package adc_cfg_pkg;

    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;

    localparam logic [5:0]  IDX_RESULT     = 6'h00;
    localparam logic [5:0]  IDX_MODE       = 6'h01;
    localparam logic [5:0]  IDX_GAIN_BIAS  = 6'h03;
    localparam logic [5:0]  IDX_CONV_FMT   = 6'h04;
    localparam logic [5:0]  IDX_IRQ_STATUS = 6'h05;

    localparam logic [7:0]  GAIN_BIAS_RST  = 8'h8B;
    localparam logic [7:0]  CONV_FMT_RST   = 8'h00;
    localparam logic [3:0]  IRQ_LOW_RST    = 4'h3;

    localparam int          BIAS_LSB       = 6;
    localparam int          GAIN_LSB       = 3;
    localparam int          CHOP_BIT       = 2;
    localparam int          SEQ_LSB        = 6;
    localparam int          LAYOUT_LSB     = 4;
    localparam int          CRC_W_BIT      = 3;
    localparam int          CRC_EN_BIT     = 2;
    localparam int          OFF_EN_BIT     = 1;
    localparam int          GAIN_EN_BIT    = 0;

    localparam logic [2:0]  GAIN_X16       = 3'h5;
    localparam logic [2:0]  GAIN_X32       = 3'h6;
    localparam logic [2:0]  GAIN_X64       = 3'h7;
    localparam logic [1:0]  SHIFT_X2       = 2'h1;
    localparam logic [1:0]  SHIFT_X4       = 2'h2;

    localparam logic [1:0]  SEQ_CONT       = 2'h3;
    localparam logic [1:0]  SEQ_STANDBY    = 2'h2;

    localparam logic [15:0] SAT_POS        = 16'hFFFF;
    localparam logic [15:0] SAT_NEG        = 16'h8000;
    localparam logic signed [23:0] MAX16   = 24'sh007FFF;
    localparam logic signed [23:0] MIN16   = -24'sh008000;
    localparam logic signed [23:0] MAX17   = 24'sh00FFFF;
    localparam logic signed [23:0] MIN17   = -24'sh010000;

    localparam logic [5:0]  CRC_BITS       = 6'h10;
    localparam logic [5:0]  CRC_PAD_BITS   = 6'h10;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        MODE_SHUT     = 2'b00,
        MODE_SHUT_ALT = 2'b01,
        MODE_STANDBY  = 2'b10,
        MODE_CONVERT  = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        LAYOUT_BARE16 = 2'b00,
        LAYOUT_LEFT32 = 2'b01,
        LAYOUT_SIGN32 = 2'b10,
        LAYOUT_CHAN32 = 2'b11
    } layout_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  channel;
        logic [16:0] data;
    } sample_t;

    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] gain;
    } cal_t;

    typedef struct packed {
        logic [1:0]  bias_current_scale;
        logic [2:0]  gain_analog;
        logic [1:0]  gain_shift;
        logic        auto_zero_chop_en;
        logic        converting;
        logic        continuous;
        logic        start;
    } afe_ctrl_t;

    typedef struct packed {
        logic        link_checksum_enable;
        logic        pad_zeros;
        logic [5:0]  trailer_bits;
    } link_crc_t;

endpackage : adc_cfg_pkg

// >>> sim/tb_top.sv
// Self-checking testbench of the ADC configuration register bank
`timescale 1ns/1ps

module tb_top;
    logic                    aclk    = 1'b0;
    logic                    aresetn = 1'b0;
    logic [7:0]              awaddr  = 8'h00;
    logic [7:0]              araddr  = 8'h00;
    logic [31:0]             wdata   = 32'h0;
    logic                    awvalid = 1'b0;
    logic                    wvalid  = 1'b0;
    logic                    bready  = 1'b0;
    logic                    arvalid = 1'b0;
    logic                    rready  = 1'b0;
    logic                    cerr    = 1'b0;
    logic                    awready, wready, bvalid, arready, rvalid;
    logic [1:0]              bresp, rresp;
    logic [31:0]             rdata, cres;
    logic                    rdy_n, integ_n, off_en, gain_en;
    adc_cfg_pkg::sample_t    smp     = '0;
    adc_cfg_pkg::cal_t       cal     = '0;
    adc_cfg_pkg::afe_ctrl_t  afe;
    adc_cfg_pkg::link_crc_t  lc;
    int                      num_errors      = 0;
    int                      samples_checked = 0;
    logic [31:0]             seed            = 32'h1C1F;

    always #50 aclk = ~aclk;

    adc_config_irq_registers dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sample(smp),
        .cal(cal), .config_checksum_error(cerr), .afe(afe), .link_crc(lc), .offset_correction_enable(off_en),
        .gain_correction_enable(gain_en), .conversion_result(cres), .result_ready_flag_n(rdy_n),
        .config_integrity_flag_n(integ_n));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected result word from raw sample and settings
    function automatic logic [31:0] fmt(logic [16:0] d, logic [3:0] ch, logic [2:0] g, logic oe, logic ge,
                                        logic [15:0] off, logic [1:0] lay);
        int          v;
        logic [15:0] s16;
        logic [16:0] v17;
        v = int'($signed(d)) * ((g == 3'h7) ? 4 : (g == 3'h6) ? 2 : 1);
        if (oe)
            v = v - int'($signed(off));
        if (ge)
            v = v / 2;
        s16 = (v > 32767) ? 16'hFFFF : (v < -32768) ? 16'h8000 : v[15:0];
        v17 = (v > 65535) ? 17'h0FFFF : (v < -65536) ? 17'h10000 : v[16:0];
        case (lay)
            2'h0: return {16'h0000, s16};
            2'h1: return {s16, 16'h0000};
            2'h2: return {{16{v17[16]}}, v17[15:0]};
            default: return {ch, {12{v17[16]}}, v17[15:0]};
        endcase
    endfunction : fmt

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        chk("bvalid", bvalid, 1);
        chk("bresp", bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        chk("rvalid", rvalid, 1);
        chk("rresp", rresp, er);
        chk("rdata", rdata, ed);
    endtask : rd

    task automatic spl(input logic [16:0] d, input logic [3:0] ch);
        @(posedge aclk);
        smp <= '{1'b1, ch, d};
        @(posedge aclk);
        smp.valid <= 1'b0;
        @(posedge aclk);
    endtask : spl

    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] g, q, e;
        logic [7:0]  gb;
        logic [1:0]  sq;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h0C, 32'h8B, adc_cfg_pkg::RESP_OKAY);
        rd(8'h10, 32'h00, adc_cfg_pkg::RESP_OKAY);
        rd(8'h04, 32'h00, adc_cfg_pkg::RESP_OKAY);
        rd(8'h14, 32'h73, adc_cfg_pkg::RESP_OKAY);
        wr(8'h14, 32'hFF, adc_cfg_pkg::RESP_OKAY);
        rd(8'h14, 32'h7F, adc_cfg_pkg::RESP_OKAY);
        wr(8'h20, 32'hFF, adc_cfg_pkg::RESP_SLVERR);
        rd(8'h20, 32'h00, adc_cfg_pkg::RESP_SLVERR);
        spl(17'h00100, 4'h1);
        chk("ignored_sample", rdy_n, 1);
        for (int i = 0; i < 16; i++)
        begin
            g  = rnd();
            q  = rnd();
            sq = i[3:2];
            cal <= '{{q[31:17], 1'b0}, 16'h4000};
            wr(8'h0C, {g[1:0], g[28:26], 3'b011}, adc_cfg_pkg::RESP_OKAY);
            wr(8'h10, {sq, i[1:0], q[3:0]}, adc_cfg_pkg::RESP_OKAY);
            wr(8'h04, 32'h3, adc_cfg_pkg::RESP_OKAY);
            spl({g[21:6], 1'b0}, g[25:22]);
            e = fmt({g[21:6], 1'b0}, g[25:22], g[28:26], q[1], q[0], {q[31:17], 1'b0}, i[1:0]);
            chk("result", cres, e);
            chk("ready_n_new", rdy_n, 0);
            chk("continuous", afe.continuous, sq == 2'h3);
            chk("converting", afe.converting, sq == 2'h3);
            chk("trailer", lc.trailer_bits, q[2] ? (q[3] ? 32 : 16) : 0);
            chk("link_en", lc.link_checksum_enable, q[2]);
            chk("cal_en", {off_en, gain_en}, q[1:0]);
            rd(8'h04, sq[1] ? {30'h0, sq} : 32'h0, adc_cfg_pkg::RESP_OKAY);
            rd(8'h00, e, adc_cfg_pkg::RESP_OKAY);
            chk("ready_n_read", rdy_n, 1);
            wr(8'h04, 32'h0, adc_cfg_pkg::RESP_OKAY);
        end
        for (int k = 0; k < 8; k++)
        begin
            q  = rnd();
            gb = {q[1:0], k[2:0], q[2], 2'b11};
            wr(8'h0C, gb, adc_cfg_pkg::RESP_OKAY);
            rd(8'h0C, gb, adc_cfg_pkg::RESP_OKAY);
            chk("gain_analog", afe.gain_analog, (k > 5) ? 5 : k);
            chk("gain_shift", afe.gain_shift, (k == 7) ? 2 : (k == 6) ? 1 : 0);
            chk("bias", afe.bias_current_scale, q[1:0]);
            chk("chop", afe.auto_zero_chop_en, q[2]);
            chk("chop_cont", afe.continuous, !q[2]);
        end
        cerr <= 1'b1;
        @(posedge aclk);
        cerr <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("integrity", integ_n, 0);
        rd(8'h14, 32'h5F, adc_cfg_pkg::RESP_OKAY);
        tally_and_finish();
    end
endmodule : tb_top
